/* verilog/rx_packet_bus_sideband.sv */
// receive bus sideband: word valid, byte modulus and abort flag toward the link layer
// assumes the port buffer logic runs on clock; link clock and host pins are asynchronous
`timescale 1ns/1ps
`default_nettype none

module rx_packet_bus_sideband
   import rx_sideband_pkg::*;
#(
   parameter int COUNT_WIDTH = 16
) (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        rst,
   // apb slave
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // host data bus pins
   input  wire logic        chipResetN,
   input  wire logic        chipSelectN,
   input  wire logic        hostReadN,
   output logic      [15:0] hostDataOut,
   output logic             hostDataOe,
   // link pins from the link layer
   input  wire logic        rxBusClock,
   input  wire logic        rxReadEnable,
   // port buffer side
   input  wire logic        portSelected,
   input  wire logic        portReady,
   input  wire logic        srcValid,
   input  var  srcWord_t    srcWord,
   output logic             srcTaken,
   // receive bus outputs
   output logic             rxWordValid,
   output logic      [31:0] rxWordBus,
   output logic             rxWordParity,
   output logic             rxFirstWord,
   output logic             rxLastWord,
   output logic      [1:0]  rxByteModulus,
   output logic             rxPacketAbortFlag,
   output logic             rxSidebandOe
);

   // squeeze the modulus into what the bus width may carry
   function automatic logic [1:0] fitModulus(input busWidth_t w, input logic [1:0] m);
      logic [1:0] r;
      r = MOD_ALL;
      case (w)
         WIDTH_32: begin
            r = (m == 2'h1) ? MOD_ALL : m;
         end
         default: begin
            r = MOD_ALL;
         end
      endcase
      return r;
   endfunction

   // pin synchronisers: bit 0 link clock, 1 read enable, 2 select, 3 read strobe
   logic [3:0] pinSync1_reg;
   logic [3:0] pinSync2_reg;
   logic [3:0] pinSync3_reg;
   logic [3:0] pinStable_reg;
   logic [3:0] pinStable_next;

   // control and status
   logic [31:0]            ctrlWord_reg;
   logic [7:0]             minDeassert_reg;
   logic [COUNT_WIDTH-1:0] wordCount_reg;
   ctrl_t                  ctrl;

   // transfer state
   xferState_t  state_reg;
   xferState_t  state_next;
   logic [7:0]  holdCount_reg;
   logic [7:0]  holdCount_next;
   logic        linkEdge;
   logic        readEn;
   logic        pktMode;
   logic        go;
   logic        load;
   logic        driveNext;
   logic        valid_reg;
   srcWord_t    word_reg;
   logic        parity_reg;
   logic        oe_reg;

   // apb decode
   logic        apbAccess;
   logic        apbWrite;
   logic        apbHit;

   // three-stage capture of asynchronous pins; only stages two and three are looked at
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         // strobes idle high; matching all stages avoids a false low after reset
         pinSync1_reg  <= 4'hc;
         pinSync2_reg  <= 4'hc;
         pinSync3_reg  <= 4'hc;
         pinStable_reg <= 4'hc;
      end else begin
         pinSync1_reg  <= {hostReadN, chipSelectN, rxReadEnable, rxBusClock};
         pinSync2_reg  <= pinSync1_reg;
         pinSync3_reg  <= pinSync2_reg;
         pinStable_reg <= pinStable_next;
      end
   end

   // a pin change counts only once the last two stages agree
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         pinStable_next[i] = (pinSync2_reg[i] == pinSync3_reg[i]) ? pinSync3_reg[i] : pinStable_reg[i];
      end
   end

   assign linkEdge = pinStable_next[0] & ~pinStable_reg[0];
   assign readEn   = pinStable_reg[1];

   // control register decode
   always_comb begin
      ctrl.mode      = busMode_t'(ctrlWord_reg[CTRL_MODE_LSB +: 2]);
      ctrl.width     = busWidth_t'(ctrlWord_reg[CTRL_WIDTH_LSB +: 2]);
      ctrl.oddParity = ctrlWord_reg[CTRL_ODD_BIT];
      ctrl.pathReset = ctrlWord_reg[CTRL_DPRST_BIT];
   end

   assign pktMode = (ctrl.mode == MODE_PKT_L2) || (ctrl.mode == MODE_PKT_L3);

   // a word goes out only for a selected port that is enabled and has data queued
   assign go = pktMode && portSelected && readEn && srcValid && !ctrl.pathReset
               && (state_reg == ST_XFER ? !word_reg.last : portReady);

   // next-state logic, evaluated only at link edges
   always_comb begin
      state_next     = state_reg;
      holdCount_next = holdCount_reg;
      load           = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            if (go) begin
               load       = 1'b1;
               state_next = ST_XFER;
            end
         end
         ST_XFER: begin
            if (go) begin
               load = 1'b1;
            end else if (ctrl.mode == MODE_PKT_L2) begin
               // a dropped read enable already satisfies the re-arm condition
               state_next = readEn ? ST_HOLD : ST_IDLE;
            end else if (ctrl.mode == MODE_PKT_L3 && minDeassert_reg != 8'h00) begin
               state_next     = ST_HOLD;
               holdCount_next = minDeassert_reg - 8'h01;
            end else begin
               state_next = ST_IDLE;
            end
         end
         ST_HOLD: begin
            if (ctrl.mode == MODE_PKT_L2) begin
               if (!readEn) begin
                  state_next = ST_IDLE;
               end
            end else if (holdCount_reg == 8'h00) begin
               state_next = ST_IDLE;
            end else begin
               holdCount_next = holdCount_reg - 8'h01;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // state registers move on link rising edges; path reset or a cell mode forces idle at once
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_reg     <= ST_IDLE;
         holdCount_reg <= 8'h00;
      end else if (ctrl.pathReset || !pktMode) begin
         state_reg     <= ST_IDLE;
         holdCount_reg <= 8'h00;
      end else if (linkEdge) begin
         state_reg     <= state_next;
         holdCount_reg <= holdCount_next;
      end
   end

   // output word and qualifiers, loaded together so valid covers them all
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         valid_reg  <= 1'b0;
         word_reg   <= '0;
         parity_reg <= 1'b0;
      end else if (ctrl.pathReset) begin
         valid_reg <= 1'b0;
      end else if (linkEdge) begin
         valid_reg <= load;
         if (load) begin
            word_reg.data    <= srcWord.data;
            word_reg.first   <= srcWord.first;
            word_reg.last    <= srcWord.last;
            // modulus and abort only carried on a last word
            word_reg.modulus <= srcWord.last ? fitModulus(ctrl.width, srcWord.modulus) : MOD_ALL;
            word_reg.abort   <= srcWord.last & srcWord.abort;
            parity_reg       <= (^srcWord.data) ^ ctrl.oddParity;
         end else begin
            word_reg.first   <= 1'b0;
            word_reg.last    <= 1'b0;
            word_reg.modulus <= MOD_ALL;
            word_reg.abort   <= 1'b0;
         end
      end
   end

   // output enable per mode; held off through reset
   always_comb begin
      case (ctrl.mode)
         MODE_CELL_L2: driveNext = 1'b0;
         MODE_PKT_L2:  driveNext = portSelected && readEn && !ctrl.pathReset;
         default:      driveNext = 1'b1;
      endcase
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         oe_reg <= 1'b0;
      end else if (ctrl.pathReset && ctrl.mode == MODE_PKT_L2) begin
         oe_reg <= 1'b0;
      end else if (linkEdge || ctrl.mode == MODE_CELL_L2) begin
         oe_reg <= driveNext;
      end
   end

   assign srcTaken          = linkEdge && load && pktMode && !ctrl.pathReset;
   assign rxWordValid       = valid_reg;
   assign rxWordBus         = word_reg.data;
   assign rxWordParity      = parity_reg;
   assign rxFirstWord       = word_reg.first;
   assign rxLastWord        = word_reg.last;
   assign rxByteModulus     = word_reg.modulus;
   assign rxPacketAbortFlag = word_reg.abort;
   assign rxSidebandOe      = oe_reg;

   // count of words delivered, wraps silently
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         wordCount_reg <= '0;
      end else if (srcTaken) begin
         wordCount_reg <= wordCount_reg + {{(COUNT_WIDTH-1){1'b0}}, 1'b1};
      end
   end

   // apb slave: zero wait states, unmapped addresses answer with an error
   assign apbAccess = psel && penable;
   assign apbWrite  = apbAccess && pwrite;
   assign apbHit    = (paddr == CTRL_OFFSET) || (paddr == MIN_DEASSERT_OFF)
                      || (paddr == STATUS_OFFSET) || (paddr == WORD_COUNT_OFF);
   assign pready    = 1'b1;
   assign pslverr   = apbAccess && !apbHit;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ctrlWord_reg    <= CTRL_RESET;
         minDeassert_reg <= MIN_DEASSERT_RESET;
      end else if (apbWrite) begin
         if (paddr == CTRL_OFFSET) begin
            ctrlWord_reg <= {26'h0, pwdata[5:0]};
         end
         if (paddr == MIN_DEASSERT_OFF) begin
            minDeassert_reg <= pwdata[7:0];
         end
      end
   end

   // read mux; status shows the live transfer state
   always_comb begin
      prdata = 32'h0000_0000;
      if (psel && !pwrite) begin
         case (paddr)
            CTRL_OFFSET:      prdata = ctrlWord_reg;
            MIN_DEASSERT_OFF: prdata = {24'h0, minDeassert_reg};
            STATUS_OFFSET:    prdata = {25'h0, oe_reg, valid_reg, readEn, pinStable_reg[0],
                                        holdCount_reg == 8'h00, state_reg};
            WORD_COUNT_OFF:   prdata = {{(32-COUNT_WIDTH){1'b0}}, wordCount_reg};
            default:          prdata = 32'h0000_0000;
         endcase
      end
   end

   // host data bus: raw reset and select pins gate the enable so it drops at once
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         hostDataOut <= 16'h0000;
      end else begin
         hostDataOut <= {9'h0, oe_reg, valid_reg, readEn, pinStable_reg[0], state_reg == ST_HOLD, state_reg};
      end
   end

   assign hostDataOe = chipResetN && !chipSelectN && !pinStable_reg[2] && !pinStable_reg[3];

endmodule // rx_packet_bus_sideband

`default_nettype wire

/* shared/rx_sideband_pkg.sv */
// constants, types and register map for the receive-side packet bus sideband
// assumes an APB register port and a link clock sampled as an ordinary input
//
// Overview of operation
// - valid high marks every bus output valid
// - valid low means no word transferred
// - outputs change only at link rising edges; path reset clears valid and the packet level 2 enable at once, cell level 2 enable updates every clock
// - valid needs selected port with block or end
// - level 2 drops valid on empty, end, disable
// - level 2 valid stays low until enable drops
// - level 3 holds valid low for minimum time
// - cell level 3 keeps valid low
// - cell level 3 keeps abort flag low
// - level 2 drives outputs only when selected, enabled
// - cell level 2 keeps outputs tri-stated always
// - level 3 modes drive outputs continuously
// - global reset tri-states the sideband outputs
// - modulus codes 00 all, 10 upper half, 11 top byte
// - modulus meaningful only with last word
// - modulus low in cell L3 and 8-bit modes
// - abort flag marks the current packet errored
// - abort flag meaningful only with last word
// - host data bus off in reset or unselected
// - host data bus 16 bits, host reads it
// - last word flag marks packet's final word
package rx_sideband_pkg;

   // register byte offsets
   localparam logic [7:0] CTRL_OFFSET      = 8'h00;
   localparam logic [7:0] MIN_DEASSERT_OFF = 8'h04;
   localparam logic [7:0] STATUS_OFFSET    = 8'h08;
   localparam logic [7:0] WORD_COUNT_OFF   = 8'h0c;

   // control field positions
   localparam int CTRL_MODE_LSB  = 0;
   localparam int CTRL_WIDTH_LSB = 2;
   localparam int CTRL_ODD_BIT   = 4;
   localparam int CTRL_DPRST_BIT = 5;

   // reset values
   localparam logic [31:0] CTRL_RESET         = 32'h0000_0000;
   localparam logic [7:0]  MIN_DEASSERT_RESET = 8'h00;

   // modulus codes
   localparam logic [1:0] MOD_ALL   = 2'h0;
   localparam logic [1:0] MOD_UPPER = 2'h2;
   localparam logic [1:0] MOD_TOP   = 2'h3;

   typedef enum logic [1:0] {
      MODE_CELL_L2 = 2'b00,
      MODE_CELL_L3 = 2'b01,
      MODE_PKT_L2  = 2'b10,
      MODE_PKT_L3  = 2'b11
   } busMode_t;

   typedef enum logic [1:0] {
      WIDTH_8  = 2'b00,
      WIDTH_16 = 2'b01,
      WIDTH_32 = 2'b10
   } busWidth_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_XFER = 2'b01,
      ST_HOLD = 2'b10
   } xferState_t;

   // one word offered by the port buffer
   typedef struct packed {
      logic [31:0] data;
      logic        first;
      logic        last;
      logic [1:0]  modulus;
      logic        abort;
   } srcWord_t;

   // decoded control register
   typedef struct packed {
      busMode_t  mode;
      busWidth_t width;
      logic      oddParity;
      logic      pathReset;
   } ctrl_t;

endpackage

/* tb/rx_sideband_checker.sv */
// checker: relations between sideband outputs and their causes at the block's ports
// assumes a bind from the bench top; one clock domain with async reset rst
`timescale 1ns/1ps
`default_nettype none

module rx_sideband_checker (
   // clock and reset
   input wire logic       clock,
   input wire logic       rst,
   // host pins
   input wire logic       chipResetN,
   input wire logic       chipSelectN,
   input wire logic       hostDataOe,
   // port buffer side
   input wire logic       portSelected,
   input wire logic       srcValid,
   input wire logic       srcTaken,
   // receive bus
   input wire logic       rxWordValid,
   input wire logic       rxLastWord,
   input wire logic [1:0] rxByteModulus,
   input wire logic       rxPacketAbortFlag,
   input wire logic       rxSidebandOe
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   // host bus and reset release
   property p_hostOff; (!chipResetN || chipSelectN) |-> !hostDataOe; endproperty
   a_hostOff: assert property (p_hostOff) else $error("host bus driven while off");
   property p_resetOff; $fell(rst) |-> !rxSidebandOe && !rxWordValid; endproperty
   a_resetOff: assert property (p_resetOff) else $error("sideband live out of reset");
   // qualifiers only on the last word; modulus code 01 never seen while driven
   property p_modLast; !rxLastWord |-> rxByteModulus == 2'h0; endproperty
   a_modLast: assert property (p_modLast) else $error("modulus set off last word");
   property p_abortLast; !rxLastWord |-> !rxPacketAbortFlag; endproperty
   a_abortLast: assert property (p_abortLast) else $error("abort set off last word");
   property p_mod01; rxSidebandOe |-> rxByteModulus != 2'h1; endproperty
   a_mod01: assert property (p_mod01) else $error("modulus code 01 seen");
   // word flow needs a source word taken first
   property p_take; srcTaken |-> portSelected && srcValid; endproperty
   a_take: assert property (p_take) else $error("word taken with no source");
   property p_validRise; $rose(rxWordValid) |-> $past(srcTaken) && rxSidebandOe; endproperty
   a_validRise: assert property (p_validRise) else $error("valid rose without a word");
   // link edges come 8 clocks apart, so valid cannot move faster
   property p_spacing; $changed(rxWordValid) |=> $stable(rxWordValid) [*6]; endproperty
   a_spacing: assert property (p_spacing) else $error("valid moved between link edges");

   c_lastUpper: cover property (rxWordValid && rxLastWord && rxByteModulus == 2'h2);
   c_abort: cover property (rxWordValid && rxPacketAbortFlag);
   c_host: cover property (hostDataOe);
endmodule // rx_sideband_checker

`default_nettype wire

/* tb/link_model.sv */
// link layer model: makes the link clock inside frames and logs received words
// assumes the bench tri-states nothing itself; enable qualifies every capture
`timescale 1ns/1ps
`default_nettype none

module link_model (
   // control from the bench
   input  wire logic        runLink,
   input  wire logic        readEnReq,
   input  wire logic        clearCount,
   // link pins
   output logic             rxBusClock,
   output logic             rxReadEnable,
   // receive bus
   input  wire logic        rxWordValid,
   input  wire logic [31:0] rxWordBus,
   input  wire logic        rxLastWord,
   input  wire logic [1:0]  rxByteModulus,
   input  wire logic        rxPacketAbortFlag,
   input  wire logic        rxSidebandOe,
   // log toward the bench
   output logic      [7:0]  wordCount,
   output logic      [31:0] lastData,
   output logic      [1:0]  lastMod,
   output logic             lastAbort
);
   // clock stands low between frames, finishing any high phase first
   initial rxBusClock = 1'b0;
   always #16 if (runLink || rxBusClock) rxBusClock = ~rxBusClock;
   assign rxReadEnable = readEnReq;

   // a word counts only with valid high on a driven bus; qualifiers only on last
   always @(posedge rxBusClock or posedge clearCount) begin
      if (clearCount) begin
         wordCount <= 8'h00;
      end else if (rxWordValid && rxSidebandOe) begin
         wordCount <= wordCount + 8'h01;
         if (rxLastWord) begin
            lastData  <= rxWordBus;
            lastMod   <= rxByteModulus;
            lastAbort <= rxPacketAbortFlag;
         end
      end
   end
endmodule // link_model

`default_nettype wire

/* tb/rx_packet_bus_sideband_test.sv */
// bench: apb setup, packet offers from the port buffer side, link model checks
// assumes rx_sideband_pkg and the checker are compiled first
`timescale 1ns/1ps
`default_nettype none

module rx_packet_bus_sideband_test;
   import rx_sideband_pkg::*;
   logic clock = 1'b0;
   logic rst, psel, penable, pwrite, pready, pslverr, chipResetN, chipSelectN, hostReadN, hostDataOe, err;
   logic rxBusClock, rxReadEnable, portSelected, portReady, srcValid, srcTaken, rxWordValid, rxWordParity;
   logic rxFirstWord, rxLastWord, rxPacketAbortFlag, rxSidebandOe, runLink, readEnReq, clearCount, lastAbort;
   logic [7:0]  paddr, wordCount, idx, pktLen;
   logic [31:0] pwdata, prdata, rxWordBus, lastData, rdata;
   logic [15:0] hostDataOut;
   logic [1:0]  rxByteModulus, lastMod, modSel;
   logic        abortSel;
   srcWord_t    srcWord;
   int          mismatches = 0;
   int          compares = 0;
   int          cycles = 0;

   rx_packet_bus_sideband dut_u (.clock, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
      .pslverr, .chipResetN, .chipSelectN, .hostReadN, .hostDataOut, .hostDataOe, .rxBusClock, .rxReadEnable,
      .portSelected, .portReady, .srcValid, .srcWord, .srcTaken, .rxWordValid, .rxWordBus, .rxWordParity,
      .rxFirstWord, .rxLastWord, .rxByteModulus, .rxPacketAbortFlag, .rxSidebandOe);
   link_model link_u (.runLink, .readEnReq, .clearCount, .rxBusClock, .rxReadEnable, .rxWordValid, .rxWordBus,
      .rxLastWord, .rxByteModulus, .rxPacketAbortFlag, .rxSidebandOe, .wordCount, .lastData, .lastMod, .lastAbort);

   always #2 clock = ~clock;
   // port buffer: words numbered from idx, qualifiers on the last only
   assign srcValid = idx < pktLen;
   assign srcWord = '{data: 32'h1000_0000 + 32'(idx), first: idx == 8'h00, last: idx == pktLen - 8'h01,
      modulus: (idx == pktLen - 8'h01) ? modSel : 2'h0, abort: (idx == pktLen - 8'h01) && abortSel};
   always @(posedge clock) if (srcTaken) idx <= idx + 8'h01;
   // hang guard, well above the several hundred cycles the run needs
   always @(posedge clock) begin
      cycles++;
      if (cycles == 30000) begin
         mismatches++;
         summarize();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // one apb transfer; read data and error taken at the completing edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rdata = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // offer a fresh packet and pulse the link count clear; nothing waits for the source to be idle
   task automatic newPkt(input logic [7:0] n, input logic [1:0] m, input logic a);
      @(posedge clock);
      pktLen <= n;
      modSel <= m;
      abortSel <= a;
      idx <= 8'h00;
      clearCount <= 1'b1;
      @(posedge clock);
      clearCount <= 1'b0;
   endtask

   task automatic waitWords(input logic [7:0] n);
      for (int i = 0; i < 400 && wordCount !== n; i++) @(posedge clock);
      repeat (24) @(posedge clock);
   endtask

   task automatic summarize;
      $display("mismatches=%0d compares=%0d", mismatches, compares);
      if (mismatches == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial begin
      rst = 1'b1;
      {psel, penable, pwrite, paddr, pwdata, runLink, clearCount, abortSel, modSel} = '0;
      {chipResetN, chipSelectN, hostReadN, readEnReq, portSelected, portReady} = 6'h3f;
      idx = 8'h00;
      pktLen = 8'h00;
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      // defaults and refused address
      apb(1'b0, CTRL_OFFSET, 32'h0);
      check(rdata, CTRL_RESET);
      check(32'(rxSidebandOe), 32'h0);
      apb(1'b1, 8'h40, 32'h3);
      check(32'(err), 32'h1);
      // cell level 2 stays off with a packet waiting
      newPkt(8'd4, 2'h0, 1'b0);
      runLink <= 1'b1;
      repeat (60) @(posedge clock);
      check(32'(rxSidebandOe), 32'h0);
      // cell level 3 drives but keeps valid, abort and modulus low
      apb(1'b1, CTRL_OFFSET, 32'h1);
      repeat (60) @(posedge clock);
      check({rxSidebandOe, rxWordValid, rxPacketAbortFlag, rxByteModulus}, 32'h10);
      // packet level 3, 32 bits, every modulus code
      apb(1'b1, MIN_DEASSERT_OFF, 32'h2);
      apb(1'b1, CTRL_OFFSET, 32'h0b);
      for (int k = 0; k < 4; k++) begin
         newPkt(8'd4, 2'(k), k[0]);
         waitWords(8'd4);
         check(32'(wordCount), 32'h4);
         check(lastData, 32'h1000_0003);
         check(32'(lastMod), 32'((k == 1) ? 0 : k));
         check(32'(lastAbort), 32'(k[0]));
         check(32'(rxWordParity), 32'(^lastData));
      end
      // packet level 2, 16 bits: valid held low until enable drops
      apb(1'b1, CTRL_OFFSET, 32'h06);
      newPkt(8'd3, 2'h3, 1'b0);
      waitWords(8'd3);
      check(32'(lastMod), 32'h0);
      newPkt(8'd3, 2'h0, 1'b0);
      repeat (60) @(posedge clock);
      check(32'(wordCount), 32'h0);
      readEnReq <= 1'b0;
      repeat (30) @(posedge clock);
      check(32'(rxSidebandOe), 32'h0);
      readEnReq <= 1'b1;
      waitWords(8'd3);
      check(32'(wordCount), 32'h3);
      portSelected <= 1'b0;
      repeat (30) @(posedge clock);
      check(32'(rxSidebandOe), 32'h0);
      // status: read enable seen, hold state after the last word, link clock bit masked
      apb(1'b0, STATUS_OFFSET, 32'h0);
      check(rdata & 32'hffff_fff7, 32'h16);
      check(32'(hostDataOut) & 32'h0000_fff7, 32'h16);
      // host data bus enable
      chipSelectN <= 1'b0;
      hostReadN <= 1'b0;
      repeat (10) @(posedge clock);
      check(32'(hostDataOe), 32'h1);
      chipResetN <= 1'b0;
      repeat (2) @(posedge clock);
      check(32'(hostDataOe), 32'h0);
      summarize();
   end
endmodule // rx_packet_bus_sideband_test

bind rx_packet_bus_sideband rx_sideband_checker chk_u (.clock, .rst, .chipResetN, .chipSelectN, .hostDataOe,
   .portSelected, .srcValid, .srcTaken, .rxWordValid, .rxLastWord, .rxByteModulus, .rxPacketAbortFlag,
   .rxSidebandOe);

`default_nettype wire
